// [design/sample_readout_pkg.sv]
// Constants shared by the four-channel sample readout design
//
// Contract
// - A rising sample_start edge puts all channels in hold and starts a run.
// - The held channels convert in order, channel 1 first, channel 4 last.
// - The start edge is taken at any time, whatever select and strobe do.
// - Converter status is shown on an active-low completion output.
// - The host reads with strobe and select both low; data drive only then.
// - Four successive reads after a conversion give channels 1, 2, 3 and 4.
// - The device counts as selected only while the active-low select is low.
// - An external clock on the clock input times conversions when given.
// - A clock pin tied to the negative rail runs the internal oscillator.
// - Results are two's complement with bus bit 11 as the MSB.
// - Bus bit 0 is the LSB and the bus floats when not read.
// - Completion goes low only after all four results are stored.
// - A full sequence takes 78 or 79 rising conversion-clock edges.
// - No channel result can be addressed; only the read order reaches them.
package sample_readout_pkg;
   localparam int unsigned CHANNELS = 4;
   localparam int unsigned RESULT_W = 12;
   localparam int unsigned CHAN_W = 2;
   // Edges per sequence once the start is aligned to the clock
   localparam int unsigned SEQ_EDGES = 78;
   localparam int unsigned EDGES_PER_CHAN = 19;
   localparam int unsigned CNT_W = 7;
   // Internal oscillator divider from clk_sys
   localparam int unsigned OSC_DIV = 50;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
endpackage

// [design/result_fifo.sv]
// Parameterised FIFO holding converted result words
`timescale 1ns/1ns
module result_fifo #(
   parameter int unsigned WIDTH = 12,
   parameter int unsigned DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic push, pop;

   assign in_ready = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
   assign out_valid = wr_ff != rd_ff;
   assign out_data = mem_ff[rd_ff[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      nxt_wr = wr_ff;
      nxt_rd = rd_ff;
      if (flush) begin
         nxt_wr = '0;
         nxt_rd = '0;
      end else begin
         if (push) nxt_wr = wr_ff + 1'b1;
         if (pop) nxt_rd = rd_ff + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
      end
   end

   // Storage has no reset; only pointers need a defined value
   always_ff @(posedge clk_sys) begin
      if (push && !flush) mem_ff[wr_ff[AW-1:0]] <= in_data;
   end
endmodule

// [design/conv_tick_gen.sv]
// Conversion clock edge detector with internal oscillator fallback
`timescale 1ns/1ns
module conv_tick_gen #(
   parameter int unsigned OSC_DIV = sample_readout_pkg::OSC_DIV
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic conv_clk,
   input wire logic use_internal,
   output logic tick
);
   logic prev_ff, nxt_prev;
   logic [15:0] div_ff, nxt_div;
   logic tick_ff, nxt_tick;

   assign tick = tick_ff;

   always_comb begin
      nxt_prev = conv_clk;
      nxt_div = div_ff;
      nxt_tick = 1'b0;
      if (use_internal) begin
         if (div_ff == 16'(OSC_DIV - 1)) begin
            nxt_div = 16'h0000;
            nxt_tick = 1'b1;
         end else begin
            nxt_div = div_ff + 16'h0001;
         end
      end else begin
         nxt_div = 16'h0000;
         nxt_tick = conv_clk && !prev_ff;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         prev_ff <= 1'b0;
         div_ff <= 16'h0000;
         tick_ff <= 1'b0;
      end else begin
         prev_ff <= nxt_prev;
         div_ff <= nxt_div;
         tick_ff <= nxt_tick;
      end
   end
endmodule

// [design/sample_readout.sv]
// Sequencer and host read port of the four-channel sample readout
`timescale 1ns/1ns
module sample_readout (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic sample_start,
   input wire logic conv_clk,
   input wire logic clk_tied_low,
   input wire logic [sample_readout_pkg::RESULT_W-1:0] adc_code,
   input wire logic cs_n,
   input wire logic rd_n,
   output logic hold,
   output logic [sample_readout_pkg::CHAN_W-1:0] conv_chan,
   output logic done_n,
   output logic [sample_readout_pkg::RESULT_W-1:0] result_bus_out,
   output logic result_bus_oe
);
   localparam int unsigned W = sample_readout_pkg::RESULT_W;
   localparam int unsigned CW = sample_readout_pkg::CNT_W;

   typedef enum logic [1:0] {ST_IDLE, ST_ALIGN, ST_CONV} seq_t;

   // -------------------------------------------------------------
   // Conversion clock
   // -------------------------------------------------------------
   logic tick;
   conv_tick_gen u_tick (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .conv_clk(conv_clk),
      .use_internal(clk_tied_low),
      .tick(tick)
   );

   // -------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------
   seq_t state_ff, nxt_state;
   logic start_prev_ff, nxt_start_prev;
   logic [CW-1:0] cnt_ff, nxt_cnt;
   logic [4:0] sub_ff, nxt_sub;
   logic [1:0] chan_ff, nxt_chan;
   logic hold_ff, nxt_hold;
   logic done_n_ff, nxt_done_n;
   logic push, push_ready, flush;
   logic start_edge, chan_end, read_end;
   logic sel_ff, nxt_sel;

   // Edge taken without regard to select or strobe
   assign start_edge = sample_start && !start_prev_ff;
   assign chan_end = tick && (state_ff == ST_CONV) &&
      (sub_ff == 5'(sample_readout_pkg::EDGES_PER_CHAN - 1));
   assign push = chan_end && push_ready;
   assign flush = start_edge;

   always_comb begin
      nxt_start_prev = sample_start;
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_sub = sub_ff;
      nxt_chan = chan_ff;
      nxt_hold = hold_ff;
      nxt_done_n = done_n_ff;
      if (read_end) nxt_done_n = 1'b1;
      if (start_edge) begin
         nxt_hold = 1'b1;
         nxt_state = ST_ALIGN;
         nxt_cnt = '0;
         nxt_sub = '0;
         nxt_chan = 2'b00;
         nxt_done_n = 1'b1;
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
            end
            ST_ALIGN: begin
               // First edge after start only aligns, giving 78 or 79
               if (tick) nxt_state = ST_CONV;
            end
            ST_CONV: begin
               if (tick) begin
                  nxt_cnt = cnt_ff + 1'b1;
                  if (chan_end) begin
                     nxt_sub = '0;
                     nxt_chan = chan_ff + 2'b01;
                  end else begin
                     nxt_sub = sub_ff + 5'b00001;
                  end
                  if (cnt_ff == CW'(sample_readout_pkg::SEQ_EDGES - 2)) begin
                     nxt_state = ST_IDLE;
                     nxt_hold = 1'b0;
                     nxt_done_n = 1'b0;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state_ff <= ST_IDLE;
         start_prev_ff <= 1'b0;
         cnt_ff <= '0;
         sub_ff <= '0;
         chan_ff <= 2'b00;
         hold_ff <= 1'b0;
         done_n_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         start_prev_ff <= nxt_start_prev;
         cnt_ff <= nxt_cnt;
         sub_ff <= nxt_sub;
         chan_ff <= nxt_chan;
         hold_ff <= nxt_hold;
         done_n_ff <= nxt_done_n;
      end
   end

   assign hold = hold_ff;
   assign conv_chan = chan_ff;
   assign done_n = done_n_ff;

   // -------------------------------------------------------------
   // Result store and read port
   // -------------------------------------------------------------
   // A FIFO, not an addressable file: only read order reaches a word
   logic out_valid;
   logic [W-1:0] out_data;
   logic [W-1:0] bus_ff, nxt_bus;
   logic oe_ff, nxt_oe;

   result_fifo #(
      .WIDTH(W),
      .DEPTH(sample_readout_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .flush(flush),
      .in_valid(push),
      .in_ready(push_ready),
      .in_data(adc_code),
      .out_valid(out_valid),
      .out_ready(read_end),
      .out_data(out_data)
   );

   // Select and strobe both low make a read access
   function automatic logic read_access(input logic sel_n,
      input logic strobe_n);
      return !sel_n && !strobe_n;
   endfunction

   // Pop when strobe or select rises at the end of an access
   assign read_end = sel_ff && !read_access(cs_n, rd_n) && out_valid;

   always_comb begin
      nxt_sel = read_access(cs_n, rd_n);
      nxt_oe = read_access(cs_n, rd_n);
      nxt_bus = out_valid ? out_data : sample_readout_pkg::RESULT_RST;
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         sel_ff <= 1'b0;
         oe_ff <= 1'b0;
         bus_ff <= sample_readout_pkg::RESULT_RST;
      end else begin
         sel_ff <= nxt_sel;
         oe_ff <= nxt_oe;
         bus_ff <= nxt_bus;
      end
   end

   assign result_bus_out = bus_ff;
   assign result_bus_oe = oe_ff;
endmodule

// [sim/sample_readout_sva.sv]
// Port checker for the sample readout
`timescale 1ns/1ns
module sample_readout_sva (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic sample_start,
   input wire logic conv_clk,
   input wire logic clk_tied_low,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic hold,
   input wire logic [1:0] conv_chan,
   input wire logic done_n,
   input wire logic result_bus_oe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // Clock pin edges since start, one seen on the start edge included
   logic [7:0] edges_ff, nxt_edges;
   logic clk_q_ff;
   always_comb begin
      nxt_edges = edges_ff;
      if (conv_clk && !clk_q_ff)
         nxt_edges = edges_ff + 8'h01;
      if (sample_start)
         nxt_edges = {7'h00, conv_clk && !clk_q_ff};
   end
   always_ff @(posedge clk_sys) begin
      edges_ff <= reset_n ? nxt_edges : 8'h00;
      clk_q_ff <= conv_clk;
   end
   start_hold_a: assert property ($rose(sample_start) |=> hold)
      else $error("hold not set by start");
   start_done_a: assert property ($rose(sample_start) |=> done_n)
      else $error("done low after start");
   chan_step_a: assert property ($changed(conv_chan) && $past(hold) &&
      hold |-> conv_chan == $past(conv_chan) + 2'h1)
      else $error("channel order broken");
   done_hold_a: assert property ($fell(done_n) |-> $past(hold))
      else $error("done without a sequence");
   seq_len_a: assert property ($fell(done_n) && !clk_tied_low
      |-> edges_ff >= 8'h4e && edges_ff <= 8'h4f)
      else $error("sequence length wrong");
   oe_sel_a: assert property (result_bus_oe |->
      $past(!cs_n && !rd_n))
      else $error("bus driven unselected");
   oe_read_a: assert property (!cs_n && !rd_n |=> result_bus_oe)
      else $error("bus not driven on read");
   bus_float_a: assert property (cs_n || rd_n |=> !result_bus_oe)
      else $error("bus not released");
   rd_clear_a: assert property ($rose(rd_n) && $past(!cs_n) && !done_n
      |=> done_n)
      else $error("done not cleared by read");
   cover property ($fell(done_n));
   cover property ($rose(result_bus_oe));
   cover property ($fell(done_n) && clk_tied_low);
endmodule
bind sample_readout sample_readout_sva i_sva (.clk_sys(clk_sys),
   .reset_n(reset_n), .sample_start(sample_start), .conv_clk(conv_clk),
   .clk_tied_low(clk_tied_low), .cs_n(cs_n), .rd_n(rd_n), .hold(hold),
   .conv_chan(conv_chan), .done_n(done_n), .result_bus_oe(result_bus_oe));

// [sim/host_model.sv]
// Host bus reader and external conversion clock
`timescale 1ns/1ns
module host_model (
   input wire logic clk_sys,
   input wire logic [11:0] bus,
   input wire logic oe,
   output logic conv_clk,
   output logic cs_n,
   output logic rd_n
);
   int div;
   initial begin
      conv_clk = 1'b0;
      cs_n = 1'b1;
      rd_n = 1'b1;
      div = 0;
   end
   // Free-running conversion clock, five system cycles per half period
   always @(posedge clk_sys) begin
      #1;
      div = (div == 4) ? 0 : div + 1;
      if (div == 0)
         conv_clk = ~conv_clk;
   end
   // Holds select and strobe until the drive is seen at an edge
   task automatic read_word(output logic [11:0] d, output bit ok);
      int n;
      n = 0;
      @(posedge clk_sys);
      #1;
      cs_n = 1'b0;
      rd_n = 1'b0;
      do @(posedge clk_sys); while (oe !== 1'b1 && n++ < 20);
      d = bus;
      ok = (oe === 1'b1);
      #1;
      cs_n = 1'b1;
      rd_n = 1'b1;
      repeat (17) @(posedge clk_sys);
   endtask
endmodule

// [sim/tb.sv]
// Self-checking bench for the sample readout
`timescale 1ns/1ns
module tb;
   logic clk_sys, reset_n, sample_start, clk_tied_low;
   logic conv_clk, cs_n, rd_n, hold, done_n, oe;
   logic [1:0] conv_chan;
   logic [11:0] adc_code, bus_out, rd_word, exp_w;
   wire [11:0] bus = oe ? bus_out : 12'hzzz;
   int errors, n_checks;
   int vals[4];
   int exp_q[$];
   bit ok;
   sample_readout i_sample_readout (.clk_sys(clk_sys), .reset_n(reset_n),
      .sample_start(sample_start), .conv_clk(conv_clk),
      .clk_tied_low(clk_tied_low), .adc_code(adc_code), .cs_n(cs_n),
      .rd_n(rd_n), .hold(hold), .conv_chan(conv_chan), .done_n(done_n),
      .result_bus_out(bus_out), .result_bus_oe(oe));
   host_model i_host_model (.clk_sys(clk_sys), .bus(bus), .oe(oe),
      .conv_clk(conv_clk), .cs_n(cs_n), .rd_n(rd_n));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      #1;
      adc_code = 12'(vals[conv_chan]);
   end
   task automatic check(logic [11:0] seen, logic [11:0] want);
      n_checks++;
      if (seen !== want) begin
         errors++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic convert(logic tie);
      int n;
      @(posedge clk_sys);
      #1;
      clk_tied_low = tie;
      sample_start = 1'b1;
      foreach (vals[i]) vals[i] = $urandom_range(4095);
      @(posedge clk_sys);
      #1;
      sample_start = 1'b0;
      @(posedge clk_sys);
      #1;
      check({11'h000, hold}, 12'h001);
      check({11'h000, done_n}, 12'h001);
      n = 0;
      while (done_n !== 1'b0 && n < 9000) begin
         @(posedge clk_sys);
         n++;
      end
      if (n == 9000) begin
         errors++;
         close_out();
      end
      // A new result set replaces whatever was left unread
      exp_q = {};
      foreach (vals[i]) exp_q.push_back(vals[i]);
   endtask
   initial begin
      reset_n = 1'b0;
      sample_start = 1'b0;
      clk_tied_low = 1'b0;
      adc_code = 12'h000;
      errors = 0;
      n_checks = 0;
      void'($urandom(22176));
      repeat (6) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
      // Run 1 stops after two reads; run 2 uses the internal clock
      for (int r = 0; r < 3; r++) begin
         convert(r == 2);
         check({11'h000, done_n}, 12'h000);
         for (int k = 0; k < (r == 1 ? 2 : 5); k++) begin
            i_host_model.read_word(rd_word, ok);
            check({11'h000, ok}, 12'h001);
            if (!ok)
               close_out();
            exp_w = 12'(exp_q.size() ? exp_q.pop_front() : 0);
            check(rd_word, exp_w);
            if (k == 0)
               check({11'h000, done_n}, 12'h001);
         end
      end
      close_out();
   end
endmodule
